/* rx_bit_sampler.sv */
// Purpose: Decides each received bit level from the oversampled line.
// Assumes: restart pulses at the falling edge that opens a character.
// Notes: bit_valid pulses once per bit period with the decided level.
`timescale 1ns/1ps
`default_nettype none
module rx_bit_sampler
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic os_tick,
  input wire logic restart,
  input wire logic high_speed_select,
  input wire logic line,
  output logic bit_valid,
  output logic bit_val
);
  logic [3:0] cnt_q;
  logic samp_a_q;
  logic samp_b_q;
  wire [3:0] edge_no = 4'(cnt_q + 4'h1);
  wire wrap = high_speed_select && (edge_no == uart_rx_pkg::EDGE_HS_LAST);
  wire [3:0] cnt_d = (restart || wrap) ? 4'h0 : edge_no;
  wire majority = (samp_a_q & samp_b_q) | (samp_a_q & line) | (samp_b_q & line);
  wire hs_hit = high_speed_select && (edge_no == uart_rx_pkg::EDGE_HS_MID);
  wire ls_hit = !high_speed_select && (edge_no == uart_rx_pkg::EDGE_MAJ_C);
  always_ff @(posedge sys_clk)
  begin
    if (srst || restart)
    begin
      cnt_q <= 4'h0;
      samp_a_q <= 1'b1;
      samp_b_q <= 1'b1;
      bit_valid <= 1'b0;
      bit_val <= 1'b1;
    end
    else if (os_tick)
    begin
      cnt_q <= cnt_d;
      samp_a_q <= (edge_no == uart_rx_pkg::EDGE_MAJ_A) ? line : samp_a_q;
      samp_b_q <= (edge_no == uart_rx_pkg::EDGE_MAJ_B) ? line : samp_b_q;
      bit_valid <= hs_hit || ls_hit;
      bit_val <= hs_hit ? line : majority;
    end
    else
    begin
      bit_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* rx_fifo.sv */
// Purpose: Receive FIFO holding each word with its error status.
// Assumes: Push is never asserted while full; pop is never asserted while empty.
// Notes: Flush empties the store in one cycle.
`timescale 1ns/1ps
`default_nettype none
module rx_fifo #(parameter int WIDTH = 11, parameter int DEPTH = 8)
(
  input wire logic sys_clk,
  input wire logic srst,
  rx_fifo_if.store f
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  wire do_push = f.push && !f.full;
  wire do_pop = f.pop && !f.empty;
  assign f.rdata = mem[rd_ptr_q];
  assign f.full = (count_q == (PW+1)'(DEPTH));
  assign f.empty = (count_q == '0);
  assign f.count = count_q;
  always_ff @(posedge sys_clk)
  begin
    if (do_push)
    begin
      mem[wr_ptr_q] <= f.wdata;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst || f.flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      wr_ptr_q <= do_push ? PW'(wr_ptr_q + 1'b1) : wr_ptr_q;
      rd_ptr_q <= do_pop ? PW'(rd_ptr_q + 1'b1) : rd_ptr_q;
      count_q <= (PW+1)'(count_q + (PW+1)'(do_push) - (PW+1)'(do_pop));
    end
  end
endmodule
`default_nettype wire

/* rx_fifo_if.sv */
// Purpose: Carries the push, pop and status signals between receiver and its FIFO.
// Assumes: One clock domain; entries are {parity error, framing error, 9 data bits}.
// Notes: The receiver owns push, wdata, pop and flush; the FIFO owns the rest.
`timescale 1ns/1ps
`default_nettype none
interface rx_fifo_if #(parameter int WIDTH = 11, parameter int DEPTH = 8);
  logic push;
  logic [WIDTH-1:0] wdata;
  logic pop;
  logic flush;
  logic [WIDTH-1:0] rdata;
  logic full;
  logic empty;
  logic [$clog2(DEPTH):0] count;
  modport producer (output push, output wdata, output pop, output flush,
                    input rdata, input full, input empty, input count);
  modport store (input push, input wdata, input pop, input flush,
                 output rdata, output full, output empty, output count);
endinterface
`default_nettype wire

/* tb.sv */
// Purpose: Self-checking bench for uart_rx_top over its register bus and serial line.
// Assumes: Baud divisor 0, so one oversample tick per sys_clk cycle.
// Notes: Expected values follow the register map and the receive behaviour.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rx_irq_flag, serial_in_pin;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, v;
  int n_mismatch = 0;
  int checks = 0;
  always #50 sys_clk = ~sys_clk;
  uart_rx_top i_dut (.sys_clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .serial_in_pin, .rx_irq_flag);
  uart_tx_model i_tx (.sys_clk, .line(serial_in_pin));
  task automatic tally_and_finish;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge sys_clk);
      ad = ad | awready;
      wd = wd | wready;
      awvalid <= !ad;
      wvalid <= !wd;
    end
    do @(posedge sys_clk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic irq(input logic e);
    @(negedge sys_clk);
    chk("irq", rx_irq_flag, e);
  endtask
  task automatic tx(input logic [8:0] w, input int nb);
    i_tx.send(w, nb, 0, 1'b0, 1'b1, 4);
  endtask
  initial
  begin
    int pd;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    rd(uart_rx_pkg::MODE_OFS);
    chk("mode", v, uart_rx_pkg::MODE_RST);
    rd(uart_rx_pkg::STAT_OFS);
    chk("stat", v, 32'h0000_0010);
    wr(uart_rx_pkg::BAUD_OFS, 32'h0000_0000);
    wr(uart_rx_pkg::STAT_OFS, 32'h0000_1000);
    wr(uart_rx_pkg::MODE_OFS, 32'h0000_8008);
    tx(9'h0A5, 8);
    rd(uart_rx_pkg::STAT_OFS);
    chk("avail", v[4:0], 32'h0000_0011);
    rd(uart_rx_pkg::HEAD_OFS);
    chk("head", v, 32'h0000_00A5);
    for (int k = 0; k < 3; k++)
    begin
      pd = k < 2 ? k + 1 : 0;
      wr(uart_rx_pkg::MODE_OFS, 32'h0000_8008 | 32'(pd << 1));
      i_tx.send(9'h0C3, 8, pd, k < 2, k != 2, 4);
      i_tx.send(9'h03C, 8, pd, 1'b0, 1'b1, 4);
      rd(uart_rx_pkg::STAT_OFS);
      chk("err", v[3:0], {k < 2, k == 2, 2'b01});
      rd(uart_rx_pkg::HEAD_OFS);
      chk("data", v, 32'h0000_00C3);
      rd(uart_rx_pkg::STAT_OFS);
      chk("clean", v[3:0], 32'h0000_0001);
      rd(uart_rx_pkg::HEAD_OFS);
      chk("next", v, 32'h0000_003C);
    end
    wr(uart_rx_pkg::MODE_OFS, 32'h0000_8001);
    i_tx.send(9'h0E1, 8, 0, 1'b0, 1'b1, 16);
    rd(uart_rx_pkg::HEAD_OFS);
    chk("slow", v, 32'h0000_00E1);
    wr(uart_rx_pkg::MODE_OFS, 32'h0000_8008);
    wr(uart_rx_pkg::STAT_OFS, 32'h0000_0000);
    wr(uart_rx_pkg::IFLAG_OFS, 32'h0000_0000);
    tx(9'h011, 8);
    rd(uart_rx_pkg::STAT_OFS);
    chk("off", v[0], 32'h0000_0000);
    wr(uart_rx_pkg::STAT_OFS, 32'h0000_1040);
    for (int i = 0; i < 8; i++)
    begin
      tx(9'(i + 1), 8);
      irq(i >= 3);
    end
    tx(9'h099, 8);
    tx(9'h09A, 8);
    rd(uart_rx_pkg::STAT_OFS);
    chk("ovr", v[1:0], 32'h0000_0003);
    rd(uart_rx_pkg::HEAD_OFS);
    chk("first", v, 32'h0000_0001);
    wr(uart_rx_pkg::IFLAG_OFS, 32'h0000_0000);
    irq(1'b1);
    wr(uart_rx_pkg::STAT_OFS, 32'h0000_1040);
    rd(uart_rx_pkg::STAT_OFS);
    chk("flush", v[1:0], 32'h0000_0000);
    wr(uart_rx_pkg::IFLAG_OFS, 32'h0000_0000);
    irq(1'b0);
    tx(9'h05A, 8);
    rd(uart_rx_pkg::HEAD_OFS);
    chk("resume", v, 32'h0000_005A);
    wr(uart_rx_pkg::MODE_OFS, 32'h0000_800E);
    wr(uart_rx_pkg::STAT_OFS, 32'h0121_10A0);
    tx(9'h121, 9);
    irq(1'b1);
    rd(uart_rx_pkg::STAT_OFS);
    chk("addr", v[0], 32'h0000_0000);
    wr(uart_rx_pkg::IFLAG_OFS, 32'h0000_0000);
    irq(1'b0);
    tx(9'h055, 9);
    tx(9'h133, 9);
    tx(9'h077, 9);
    rd(uart_rx_pkg::HEAD_OFS);
    chk("match", v, 32'h0000_0055);
    rd(uart_rx_pkg::STAT_OFS);
    chk("drop", v[0], 32'h0000_0000);
    wr(8'h20, 32'h0000_0000);
    chk("bresp", r, uart_rx_pkg::RESP_SLVERR);
    rd(8'h20);
    chk("rresp", r, uart_rx_pkg::RESP_SLVERR);
    wr(uart_rx_pkg::MODE_OFS, 32'h0000_000E);
    irq(1'b0);
    rd(uart_rx_pkg::STAT_OFS);
    chk("kept", v & uart_rx_pkg::STAT_WMASK, 32'h0121_10A0);
    tally_and_finish;
  end
  initial
  begin
    #(100 * 60000);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

/* uart_rx_pkg.sv */
// Purpose: Shared constants and types for the serial receive path with address detection.
// Assumes: One 10 MHz clock; AXI4-Lite registers, one aligned 32-bit word each. Notes: the rules follow.
// Contract
// - High-speed select 0 oversamples at 16x and decides bits by majority.
// - High-speed select 1 oversamples at 4x and decides from one sample.
// - After the stop bit the character moves into the FIFO if not full.
// - Reception happens only while receive enable, status bit 12, is set.
// - FIFO holds 8 words of 9 bits, head readable through a register.
// - A full FIFO does not stop shifting in the next character.
// - Character completing into a full FIFO sets overrun, status bit 1, and is lost.
// - While overrun is set no FIFO writes happen; software clears it.
// - Stop bit sampled low sets framing error, status bit 2.
// - Parity error, status bit 3, reports head word mismatch; meaningless in 9-bit mode.
// - Framing and parity status are stored per word and shown with it.
// - Select field at status bits 7:6 picks the receive interrupt condition.
// - Receive interrupt flag stays set while the selected condition holds.
// - Receiver idle, status bit 4, is set while the shift register is empty; the code sets it while the state is RX_IDLE.
// - Data available, status bit 0, is set while the FIFO holds a word.
// - Address detect, status bit 5, drops ninth-bit-0 words in 9-bit mode only.
// - Data and parity select 11 at mode bits 2:1 picks 9-bit, no parity.
// - An address character with address detect on always raises the interrupt.
// - Match address bits 23:16 and auto match bit 24 select following data words.
// - In 16x mode each bit is sampled at edges 7, 8 and 9.
// - In 4x mode each bit is sampled once at mid-bit.
// - Clearing module enable aborts reception and resets; configuration is kept.
package uart_rx_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] HEAD_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] BAUD_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] IFLAG_OFS = 8'h10;
  localparam int MODE_ON_BIT = 15;
  localparam int MODE_HS_BIT = 3;
  localparam int MODE_PD_LSB = 1;
  localparam int MODE_STOP_BIT = 0;
  localparam int STAT_DA_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int STAT_PARITY_ERROR_FLAG_BIT = 3;
  localparam int STAT_IDLE_BIT = 4;
  localparam int STAT_ADEN_BIT = 5;
  localparam int STAT_ISEL_LSB = 6;
  localparam int STAT_RXEN_BIT = 12;
  localparam int STAT_ADDR_LSB = 16;
  localparam int STAT_AUTO_BIT = 24;
  localparam int IFLAG_RX_BIT = 0;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MODE_WMASK = 32'h0000_800F;
  localparam logic [31:0] STAT_RST = 32'h0000_0000;
  localparam logic [31:0] STAT_WMASK = 32'h01FF_10E0;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  localparam logic [3:0] EDGE_MAJ_A = 4'h7;
  localparam logic [3:0] EDGE_MAJ_B = 4'h8;
  localparam logic [3:0] EDGE_MAJ_C = 4'h9;
  localparam logic [3:0] EDGE_HS_MID = 4'h2;
  localparam logic [3:0] EDGE_HS_LAST = 4'h4;
  localparam logic [1:0] PD_8_EVEN = 2'h1;
  localparam logic [1:0] PD_8_ODD = 2'h2;
  localparam logic [1:0] PD_9_NONE = 2'h3;
  localparam logic [3:0] ISEL_LVL_HALF = 4'h4;
  localparam logic [3:0] ISEL_LVL_3Q = 4'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

/* uart_rx_top.sv */
// Purpose: Serial receive path with FIFO, error status, receive interrupt and address matching.
// Assumes: serial_in_pin is synchronous to sys_clk; the baud divisor sets the oversample tick.
// Notes: Registers answer over AXI4-Lite; unmapped addresses answer SLVERR.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_top #(parameter int FIFO_DEPTH = 8, parameter int DATA_W = 9)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic serial_in_pin,
  output logic rx_irq_flag
);
  localparam int EW = DATA_W + 2;

  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~m) | (nw & m);
  endfunction

  rx_fifo_if #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) fif ();

  rx_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .f(fif.store)
  );

  logic [31:0] mode_q;
  logic [31:0] stat_q;
  logic [15:0] baud_q;
  logic overrun_flag_q;
  logic matched_q;
  logic [15:0] div_q;
  logic os_tick_q;
  logic line_q;
  uart_rx_pkg::rx_state_t state_q;
  logic [DATA_W-1:0] rx_shift_reg_q;
  logic [3:0] bit_idx_q;
  logic stop_idx_q;
  logic par_bit_q;
  logic framing_error_flag_q;
  logic aw_got_q;
  logic w_got_q;
  logic [uart_rx_pkg::ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bit_valid;
  logic bit_val;

  // Configuration fields.
  wire module_on = mode_q[uart_rx_pkg::MODE_ON_BIT];
  wire high_speed_select = mode_q[uart_rx_pkg::MODE_HS_BIT];
  wire [1:0] data_parity_select = mode_q[uart_rx_pkg::MODE_PD_LSB +: 2];
  wire stop_count_select = mode_q[uart_rx_pkg::MODE_STOP_BIT];
  wire rx_enable_bit = stat_q[uart_rx_pkg::STAT_RXEN_BIT];
  wire address_detect_enable = stat_q[uart_rx_pkg::STAT_ADEN_BIT];
  wire [1:0] rx_irq_select = stat_q[uart_rx_pkg::STAT_ISEL_LSB +: 2];
  wire [7:0] match_addr = stat_q[uart_rx_pkg::STAT_ADDR_LSB +: 8];
  wire auto_match_enable = stat_q[uart_rx_pkg::STAT_AUTO_BIT];
  wire nine_bit = (data_parity_select == uart_rx_pkg::PD_9_NONE);
  wire parity_on = (data_parity_select == uart_rx_pkg::PD_8_EVEN) ||
                   (data_parity_select == uart_rx_pkg::PD_8_ODD);
  wire run = module_on && rx_enable_bit;

  // Oversampling tick from the divisor.
  wire div_hit = (div_q == baud_q);

  always_ff @(posedge sys_clk)
  begin
    if (srst || !run)
    begin
      div_q <= 16'h0000;
      os_tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_hit ? 16'h0000 : 16'(div_q + 16'h0001);
      os_tick_q <= div_hit;
    end
  end

  // Start detection on the falling edge of the idle-high line.
  wire start_edge = run && (state_q == uart_rx_pkg::RX_IDLE) && line_q && !serial_in_pin;

  rx_bit_sampler u_sampler
  (
    .sys_clk(sys_clk),
    .srst(srst),
    .os_tick(os_tick_q),
    .restart(start_edge),
    .high_speed_select(high_speed_select),
    .line(serial_in_pin),
    .bit_valid(bit_valid),
    .bit_val(bit_val)
  );

  // Character assembly.
  wire [3:0] last_idx = nine_bit ? 4'h8 : 4'h7;
  wire [DATA_W-1:0] shift_in = {bit_val, rx_shift_reg_q[DATA_W-1:1]};
  wire last_stop = !stop_count_select || stop_idx_q;
  wire complete = (state_q == uart_rx_pkg::RX_STOP) && bit_valid && last_stop;
  wire framing_error_flag_now = framing_error_flag_q || !bit_val;
  wire [DATA_W-1:0] word = nine_bit ? rx_shift_reg_q : {1'b0, rx_shift_reg_q[DATA_W-1:1]};
  wire par_sum = ^word[7:0] ^ par_bit_q;
  wire parity_error_flag_now = parity_on &&
                  ((data_parity_select == uart_rx_pkg::PD_8_EVEN) ? par_sum : !par_sum);

  // Address filtering in 9-bit mode.
  wire aden_eff = address_detect_enable && nine_bit;
  wire addr_char = nine_bit && word[8];
  wire addr_hit = (word[7:0] == match_addr);
  wire keep_word = !aden_eff ? 1'b1 :
                   (addr_char ? !auto_match_enable : (auto_match_enable && matched_q));
  wire addr_event = complete && aden_eff && addr_char;
  wire store_try = complete && keep_word;
  wire overflow = store_try && (fif.full || overrun_flag_q);

  always_ff @(posedge sys_clk)
  begin
    if (srst || !run)
    begin
      state_q <= uart_rx_pkg::RX_IDLE;
      rx_shift_reg_q <= '0;
      bit_idx_q <= 4'h0;
      stop_idx_q <= 1'b0;
      par_bit_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      line_q <= 1'b1;
    end
    else
    begin
      line_q <= serial_in_pin;
      case (state_q)
        uart_rx_pkg::RX_IDLE:
        begin
          if (start_edge)
          begin
            state_q <= uart_rx_pkg::RX_START;
          end
        end
        uart_rx_pkg::RX_START:
        begin
          if (bit_valid)
          begin
            state_q <= bit_val ? uart_rx_pkg::RX_IDLE : uart_rx_pkg::RX_DATA;
            bit_idx_q <= 4'h0;
            stop_idx_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
          end
        end
        uart_rx_pkg::RX_DATA:
        begin
          if (bit_valid)
          begin
            rx_shift_reg_q <= shift_in;
            bit_idx_q <= 4'(bit_idx_q + 4'h1);
            if (bit_idx_q == last_idx)
            begin
              state_q <= parity_on ? uart_rx_pkg::RX_PARITY : uart_rx_pkg::RX_STOP;
            end
          end
        end
        uart_rx_pkg::RX_PARITY:
        begin
          if (bit_valid)
          begin
            par_bit_q <= bit_val;
            state_q <= uart_rx_pkg::RX_STOP;
          end
        end
        uart_rx_pkg::RX_STOP:
        begin
          if (bit_valid)
          begin
            framing_error_flag_q <= framing_error_flag_now;
            stop_idx_q <= 1'b1;
            if (last_stop)
            begin
              state_q <= uart_rx_pkg::RX_IDLE;
            end
          end
        end
        default:
        begin
          state_q <= uart_rx_pkg::RX_IDLE;
        end
      endcase
    end
  end

  // Bus write path: address and data are taken in either order.
  wire aw_fire = awvalid && awready;
  wire w_fire = wvalid && wready;
  wire aw_have = aw_got_q || aw_fire;
  wire w_have = w_got_q || w_fire;
  wire [uart_rx_pkg::ADDR_W-1:0] wr_addr = aw_got_q ? aw_addr_q : awaddr;
  wire [31:0] wr_data = w_got_q ? w_data_q : wdata;
  wire [3:0] wr_strb = w_got_q ? w_strb_q : wstrb;
  wire do_write = aw_have && w_have && !bvalid;
  wire wr_mode = do_write && (wr_addr == uart_rx_pkg::MODE_OFS);
  wire wr_stat = do_write && (wr_addr == uart_rx_pkg::STAT_OFS);
  wire wr_baud = do_write && (wr_addr == uart_rx_pkg::BAUD_OFS);
  wire wr_iflag = do_write && (wr_addr == uart_rx_pkg::IFLAG_OFS);
  wire wr_head = do_write && (wr_addr == uart_rx_pkg::HEAD_OFS);
  wire wr_ok = wr_mode || wr_stat || wr_baud || wr_iflag || wr_head;
  wire ovr_clear = wr_stat && wr_strb[0] && !wr_data[uart_rx_pkg::STAT_OVR_BIT];
  wire irq_clear = wr_iflag && wr_strb[0] && !wr_data[uart_rx_pkg::IFLAG_RX_BIT];
  wire aw_hold_d = aw_have && !do_write;
  wire w_hold_d = w_have && !do_write;
  wire bvalid_d = do_write || (bvalid && !bready);

  // Bus read path; reading the head pops the FIFO.
  wire ar_fire = arvalid && arready;
  wire [EW-1:0] head = fif.empty ? '0 : fif.rdata;
  wire [31:0] stat_view = (stat_q & uart_rx_pkg::STAT_WMASK) |
                          (32'(!fif.empty) << uart_rx_pkg::STAT_DA_BIT) |
                          (32'(overrun_flag_q) << uart_rx_pkg::STAT_OVR_BIT) |
                          (32'(head[DATA_W]) << uart_rx_pkg::STAT_FRAMING_ERROR_FLAG_BIT) |
                          (32'(head[DATA_W+1]) << uart_rx_pkg::STAT_PARITY_ERROR_FLAG_BIT) |
                          (32'(state_q == uart_rx_pkg::RX_IDLE) << uart_rx_pkg::STAT_IDLE_BIT);
  wire rd_mode = (araddr == uart_rx_pkg::MODE_OFS);
  wire rd_stat = (araddr == uart_rx_pkg::STAT_OFS);
  wire rd_head = (araddr == uart_rx_pkg::HEAD_OFS);
  wire rd_baud = (araddr == uart_rx_pkg::BAUD_OFS);
  wire rd_iflag = (araddr == uart_rx_pkg::IFLAG_OFS);
  wire rd_ok = rd_mode || rd_stat || rd_head || rd_baud || rd_iflag;
  wire [31:0] rd_word = rd_mode ? mode_q :
                        rd_stat ? stat_view :
                        rd_head ? 32'(head[DATA_W-1:0]) :
                        rd_baud ? 32'(baud_q) :
                        rd_iflag ? 32'(rx_irq_flag) : 32'h0000_0000;

  // FIFO control.
  assign fif.push = store_try && !overflow && run;
  assign fif.wdata = {parity_error_flag_now, framing_error_flag_now, word};
  assign fif.pop = ar_fire && rd_head && !fif.empty;
  assign fif.flush = !module_on || (ovr_clear && overrun_flag_q && !overflow);

  // Receive interrupt condition.
  wire irq_cond = (rx_irq_select == 2'h1) ? (fif.count >= 4'(uart_rx_pkg::ISEL_LVL_HALF)) :
                  (rx_irq_select == 2'h2) ? (fif.count >= 4'(uart_rx_pkg::ISEL_LVL_3Q)) :
                  !fif.empty;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      mode_q <= uart_rx_pkg::MODE_RST;
      stat_q <= uart_rx_pkg::STAT_RST;
      baud_q <= uart_rx_pkg::BAUD_RST;
      overrun_flag_q <= 1'b0;
      matched_q <= 1'b0;
      rx_irq_flag <= 1'b0;
    end
    else
    begin
      if (wr_mode)
      begin
        mode_q <= merge_strb(mode_q, wr_data, wr_strb, uart_rx_pkg::MODE_WMASK);
      end
      if (wr_stat)
      begin
        stat_q <= merge_strb(stat_q, wr_data, wr_strb, uart_rx_pkg::STAT_WMASK);
      end
      if (wr_baud)
      begin
        baud_q <= 16'(merge_strb(32'(baud_q), wr_data, wr_strb, 32'h0000_FFFF));
      end
      if (!module_on)
      begin
        overrun_flag_q <= 1'b0;
        matched_q <= 1'b0;
        rx_irq_flag <= 1'b0;
      end
      else
      begin
        overrun_flag_q <= overflow || (overrun_flag_q && !ovr_clear);
        if (complete && aden_eff && addr_char && auto_match_enable)
        begin
          matched_q <= addr_hit;
        end
        rx_irq_flag <= irq_cond || addr_event || (rx_irq_flag && !irq_clear);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= uart_rx_pkg::RESP_OKAY;
    end
    else
    begin
      aw_got_q <= aw_hold_d;
      w_got_q <= w_hold_d;
      aw_addr_q <= aw_fire ? awaddr : aw_addr_q;
      w_data_q <= w_fire ? wdata : w_data_q;
      w_strb_q <= w_fire ? wstrb : w_strb_q;
      awready <= !aw_hold_d && !bvalid_d;
      wready <= !w_hold_d && !bvalid_d;
      bvalid <= bvalid_d;
      bresp <= do_write ? (wr_ok ? uart_rx_pkg::RESP_OKAY : uart_rx_pkg::RESP_SLVERR) : bresp;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= uart_rx_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= rd_ok ? uart_rx_pkg::RESP_OKAY : uart_rx_pkg::RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
    else
    begin
      arready <= !rvalid;
    end
  end
endmodule
`default_nettype wire

/* uart_rx_top_props.sv */
// Purpose: Concurrent checks on the register bus answers and the receive interrupt of uart_rx_top.
// Assumes: Write address and data are offered together and taken at one edge.
// Notes: Bound to every uart_rx_top instance.
`timescale 1ns/1ps
`default_nettype none
module uart_rx_top_props #(parameter int FIFO_DEPTH = 8, parameter int DATA_W = 9)
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [uart_rx_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic rx_irq_flag
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  logic aw_bad_q, ar_bad_q, ar_head_q;
  wire logic aw_take = awvalid && awready;
  wire logic wr_take = aw_take && wvalid && wready;
  wire logic ar_take = arvalid && arready;
  wire logic aw_map = awaddr[1:0] == 2'h0 && awaddr <= uart_rx_pkg::IFLAG_OFS;
  wire logic ar_map = araddr[1:0] == 2'h0 && araddr <= uart_rx_pkg::IFLAG_OFS;
  wire logic turn_off = wr_take && awaddr == uart_rx_pkg::MODE_OFS && wstrb[1] && !wdata[uart_rx_pkg::MODE_ON_BIT];
  // The captured address decides which response code the answer must carry.
  always_ff @(posedge sys_clk)
  begin
    if (srst || aw_take)
      aw_bad_q <= !srst && !aw_map;
    if (srst || ar_take)
      ar_bad_q <= !srst && !ar_map;
    if (srst || ar_take)
      ar_head_q <= !srst && araddr == uart_rx_pkg::HEAD_OFS;
  end
  a_bvalid_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response withdrawn before bready.");
  a_rvalid_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("Read answer changed before rready.");
  a_write_answer: assert property (wr_take && !bvalid |=> bvalid)
    else $error("Write response missing one cycle after the take.");
  a_read_answer: assert property (ar_take |=> rvalid && !arready)
    else $error("Read answer missing one cycle after the take.");
  a_wr_resp_code: assert property (bvalid |-> bresp == (aw_bad_q ? uart_rx_pkg::RESP_SLVERR : uart_rx_pkg::RESP_OKAY))
    else $error("Write response code does not match the address.");
  a_rd_resp_code: assert property (rvalid |-> rresp == (ar_bad_q ? uart_rx_pkg::RESP_SLVERR : uart_rx_pkg::RESP_OKAY))
    else $error("Read response code does not match the address.");
  a_head_width: assert property (rvalid && ar_head_q |-> rdata[31:DATA_W] == '0)
    else $error("Receive head read carries bits above the word width.");
  a_off_clears_irq: assert property (turn_off |-> ##[1:3] !rx_irq_flag)
    else $error("Receive interrupt flag survived module disable.");
endmodule
bind uart_rx_top uart_rx_top_props #(.FIFO_DEPTH(FIFO_DEPTH), .DATA_W(DATA_W)) i_props (.sys_clk, .srst, .awaddr,
  .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready, .rx_irq_flag);
`default_nettype wire

/* uart_tx_model.sv */
// Purpose: Remote serial transmitter driving the receive line.
// Assumes: A bit period is a whole number of sys_clk cycles; the line idles high.
// Notes: Parity and stop level can be sent wrong on request.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_model
(
  input wire logic sys_clk,
  output logic line
);
  initial line = 1'b1;
  task automatic put(input logic b, input int bc);
    @(posedge sys_clk);
    line <= b;
    repeat (bc - 1) @(posedge sys_clk);
  endtask
  // Sends start, data from the least significant bit, optional parity, stop, then two idle bits.
  task automatic send(input logic [8:0] w, input int nb, input int par, input logic bad, input logic stp, input int bc);
    put(1'b0, bc);
    for (int i = 0; i < nb; i++)
      put(w[i], bc);
    if (par != 0)
      put(^w[7:0] ^ (par == 2) ^ bad, bc);
    put(stp, bc);
    put(1'b1, 2 * bc);
  endtask
endmodule
`default_nettype wire
